// ---- rtl/smbsl_pkg.sv ----
// constants and types shared by the smbus slave front end
`default_nettype none
package smbsl_pkg;

    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned ERASE_TIME_MS = 20;
    localparam int unsigned ERASE_CYCLES_DOC = ERASE_TIME_MS * (CLK_HZ / 1000);
    localparam int ERASE_CNT_W = 19;

    // ************************************************************
    // addressing
    // ************************************************************
    localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h09;
    localparam logic [7:0] RAM_TOP = 8'hdf;
    localparam logic [7:0] EE_HI_FIRST = 8'hf8;
    localparam logic [7:0] EE_HI_LAST = 8'hfb;
    localparam logic [15:0] EE_BASE = 16'hf800;
    localparam logic [15:0] EE_TOP = 16'hfbfe;
    localparam logic [15:0] RAM_TOP_ADDR = 16'h00df;
    localparam int PAGE_LSB = 5;
    localparam int PAGE_MSB = 9;
    localparam int PAGE_W = 5;

    // ************************************************************
    // commands and the update configuration register
    // ************************************************************
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'hfc;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'hfe;
    localparam logic [15:0] UPD_CFG_ADDR = 16'h0090;
    localparam int UPD_CFG_ERASE_EN_BIT = 2;
    localparam logic [7:0] UPD_CFG_RESET = 8'h00;

    // ************************************************************
    // write stream buffer
    // ************************************************************
    localparam int WR_FIFO_W = 24;
    localparam int WR_FIFO_DEPTH = 16;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_RX_ACK = 3'b010,
        ST_TX = 3'b011,
        ST_TX_ACK = 3'b100
    } smbsl_state_t;

endpackage
`default_nettype wire

// ---- rtl/smbsl_sync.sv ----
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module smbsl_sync
#(
    parameter int W = 1
)
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } smbsl_sync_t;

    smbsl_sync_t q;
    smbsl_sync_t d;

    // released bus lines idle high, so reset to ones
    always_comb
    begin
        d = q;
        d.s1 = d_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            q <= '1;
        else
            q <= d;
    end

    assign q_out = q.s2;
endmodule
`default_nettype wire

// ---- rtl/smbsl_fifo.sv ----
// valid/ready fifo buffering received write bytes
`timescale 1ns/10ps
`default_nettype none
module smbsl_fifo
#(
    parameter int W = 8,
    parameter int DEPTH = 16
)
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } smbsl_fifo_t;

    smbsl_fifo_t q;
    smbsl_fifo_t d;
    logic [W-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready_out = (q.count != (AW+1)'(DEPTH));
    assign out_valid_out = (q.count != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[q.rp];

    always_comb
    begin
        d = q;
        if (push)
            d.wp = q.wp + 1'b1;
        if (pop)
            d.rp = q.rp + 1'b1;
        if (push && !pop)
            d.count = q.count + 1'b1;
        else if (pop && !push)
            d.count = q.count - 1'b1;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            q <= '0;
        else
            q <= d;
    end

    // storage needs no reset; count guards every read
    always_ff @(posedge sys_clk_in)
    begin
        if (push)
            mem[q.wp] <= in_data_in;
    end
endmodule
`default_nettype wire

// ---- rtl/smbsl_slave.sv ----
// smbus slave front end: framing, addressing, pointer and page erase
`timescale 1ns/10ps
`default_nettype none
module smbsl_slave
    import smbsl_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = ERASE_CYCLES_DOC
)
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_b_out,
    input wire logic address_select_hi_in,
    input wire logic address_select_lo_in,
    output logic [15:0] ptr_out,
    input wire logic [7:0] rd_data_in,
    output logic wr_valid_out,
    input wire logic wr_ready_in,
    output logic [15:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    output logic [7:0] update_config_control_out,
    output logic erase_start_out,
    output logic erase_busy_out,
    output logic [PAGE_W-1:0] erase_page_out
);
    typedef struct packed {
        smbsl_state_t st;
        logic [3:0] bitcnt;
        logic [1:0] byte_idx;
        logic [7:0] shift;
        logic rw;
        logic nack;
        logic [7:0] cmd;
        logic [15:0] ptr;
        logic [7:0] cfg;
        logic oe_b;
        logic busy;
        logic [ERASE_CNT_W-1:0] cnt;
        logic [PAGE_W-1:0] page;
        logic start_p;
        logic scl_p;
        logic sda_p;
    } smbsl_slave_t;

    smbsl_slave_t q;
    smbsl_slave_t d;
    logic [3:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [6:0] own_addr;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic decide;
    logic ack;
    logic push;
    logic fifo_ready;
    logic mapped;
    logic ee_cmd;
    logic [7:0] rd_byte;

    // ************************************************************
    // pin synchronisers and buffering
    // ************************************************************
    smbsl_sync #(.W(4)) u_sync (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .d_in({scl_in, sda_in, address_select_hi_in, address_select_lo_in}),
        .q_out(pins_s)
    );

    smbsl_fifo #(.W(WR_FIFO_W), .DEPTH(WR_FIFO_DEPTH)) u_fifo (
        .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .in_valid_in(push),
        .in_ready_out(fifo_ready),
        .in_data_in({q.ptr, q.shift}),
        .out_valid_out(wr_valid_out),
        .out_ready_in(wr_ready_in),
        .out_data_out({wr_addr_out, wr_data_out})
    );

    // ************************************************************
    // bus conditions
    // ************************************************************
    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];
    assign own_addr = {SLAVE_ADDR_FIXED, pins_s[1:0]};
    assign start_det = scl_s && q.scl_p && q.sda_p && !sda_s;
    assign stop_det = scl_s && q.scl_p && !q.sda_p && sda_s;
    assign scl_rise = scl_s && !q.scl_p;
    assign scl_fall = !scl_s && q.scl_p;
    assign decide = (q.st == ST_RX) && scl_fall && (q.bitcnt == BITS_PER_BYTE);
    assign ee_cmd = (q.cmd >= EE_HI_FIRST) && (q.cmd <= EE_HI_LAST);
    assign mapped = (q.ptr <= RAM_TOP_ADDR)
        || ((q.ptr >= EE_BASE) && (q.ptr <= EE_TOP));
    assign rd_byte = (q.ptr == UPD_CFG_ADDR) ? q.cfg : rd_data_in;

    // ************************************************************
    // protocol engine
    // ************************************************************
    always_comb
    begin
        d = q;
        ack = 1'b0;
        push = 1'b0;
        d.scl_p = scl_s;
        d.sda_p = sda_s;
        d.start_p = 1'b0;
        if (q.busy)
        begin
            if (q.cnt == ERASE_CNT_W'(ERASE_CYCLES - 1))
                d.busy = 1'b0;
            else
                d.cnt = q.cnt + 1'b1;
        end
        if (start_det)
        begin
            d.st = ST_RX;
            d.bitcnt = '0;
            d.byte_idx = '0;
            d.oe_b = 1'b1;
        end
        else if (stop_det)
        begin
            d.st = ST_IDLE;
            d.oe_b = 1'b1;
        end
        else
        begin
            unique case (q.st)
                ST_IDLE:
                    d.oe_b = 1'b1;
                ST_RX:
                begin
                    if (scl_rise && q.bitcnt != BITS_PER_BYTE)
                    begin
                        d.shift = {q.shift[6:0], sda_s};
                        d.bitcnt = q.bitcnt + 1'b1;
                    end
                    else if (decide)
                    begin
                        if (q.byte_idx == 2'd0)
                        begin
                            // a running erase refuses every access
                            ack = (q.shift[7:1] == own_addr) && !q.busy;
                            d.rw = q.shift[0];
                        end
                        else if (q.byte_idx == 2'd1)
                        begin
                            ack = 1'b1;
                            d.cmd = q.shift;
                            if (q.shift <= RAM_TOP)
                                d.ptr = {8'h00, q.shift};
                            else if (q.shift >= EE_HI_FIRST
                                && q.shift <= EE_HI_LAST)
                                d.ptr[15:8] = q.shift;
                            else if (q.shift == CMD_PAGE_ERASE
                                && q.cfg[UPD_CFG_ERASE_EN_BIT])
                            begin
                                d.busy = 1'b1;
                                d.cnt = '0;
                                d.start_p = 1'b1;
                                d.page = q.ptr[PAGE_MSB:PAGE_LSB];
                            end
                        end
                        else if (ee_cmd && q.byte_idx == 2'd2)
                        begin
                            ack = 1'b1;
                            d.ptr[7:0] = q.shift;
                        end
                        else if (q.cmd == CMD_BLOCK_WRITE && q.byte_idx == 2'd2)
                            ack = 1'b1;
                        else if (q.cmd <= RAM_TOP || ee_cmd
                            || q.cmd == CMD_BLOCK_WRITE)
                        begin
                            // a full buffer refuses the byte instead of losing it
                            ack = fifo_ready;
                            push = fifo_ready && mapped;
                            if (fifo_ready)
                                d.ptr = q.ptr + 16'h0001;
                            if (fifo_ready && q.ptr == UPD_CFG_ADDR)
                                d.cfg = q.shift;
                        end
                        else
                            ack = 1'b1;
                        if (q.byte_idx != 2'd3)
                            d.byte_idx = q.byte_idx + 1'b1;
                        d.oe_b = !ack;
                        d.st = ack ? ST_RX_ACK : ST_IDLE;
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        d.bitcnt = '0;
                        d.oe_b = 1'b1;
                        d.st = ST_RX;
                        if (q.rw)
                        begin
                            d.shift = rd_byte;
                            d.oe_b = rd_byte[7];
                            d.bitcnt = 4'h1;
                            d.st = ST_TX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (q.bitcnt == BITS_PER_BYTE)
                        begin
                            d.oe_b = 1'b1;
                            d.st = ST_TX_ACK;
                        end
                        else
                        begin
                            d.oe_b = q.shift[6];
                            d.shift = {q.shift[6:0], 1'b0};
                            d.bitcnt = q.bitcnt + 1'b1;
                        end
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        d.nack = sda_s;
                        if (!sda_s)
                            d.ptr = q.ptr + 16'h0001;
                    end
                    else if (scl_fall)
                    begin
                        if (q.nack)
                            d.st = ST_IDLE;
                        else
                        begin
                            d.shift = rd_byte;
                            d.oe_b = rd_byte[7];
                            d.bitcnt = 4'h1;
                            d.st = ST_TX;
                        end
                    end
                end
                default:
                begin
                    d.st = ST_IDLE;
                    d.oe_b = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            q <= '0;
            q.cfg <= UPD_CFG_RESET;
            q.oe_b <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_p <= 1'b1;
        end
        else
            q <= d;
    end

    // open drain: the pad only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe_b_out = q.oe_b;
    assign ptr_out = q.ptr;
    assign update_config_control_out = q.cfg;
    assign erase_start_out = q.start_p;
    assign erase_busy_out = q.busy;
    assign erase_page_out = q.page;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);

    property p_start_restarts;
        start_det |=> q.st == ST_RX && q.bitcnt == 4'h0 && q.byte_idx == 2'd0;
    endproperty
    a_start_restarts: assert property (p_start_restarts)
        else $error("start did not restart the byte shifter");
    property p_rw_latched;
        decide && q.byte_idx == 2'd0 && q.shift[7:1] == own_addr && !q.busy
            |=> q.rw == $past(q.shift[0]) && q.st == ST_RX_ACK;
    endproperty
    a_rw_latched: assert property (p_rw_latched)
        else $error("direction bit not taken on address match");
    property p_ack_low;
        q.st == ST_RX_ACK |-> !sda_oe_b_out;
    endproperty
    a_ack_low: assert property (p_ack_low)
        else $error("sda released during acknowledge");
    property p_mismatch_idle;
        decide && q.byte_idx == 2'd0 && q.shift[7:1] != own_addr
            |=> q.st == ST_IDLE ##1 sda_oe_b_out;
    endproperty
    a_mismatch_idle: assert property (p_mismatch_idle)
        else $error("slave did not go idle on foreign address");
    property p_ptr_load;
        decide && q.byte_idx == 2'd1 && q.shift <= RAM_TOP
            |=> ptr_out == {8'h00, $past(q.shift)};
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer not loaded from command address");
    property p_erase_gate;
        erase_start_out |-> update_config_control_out[UPD_CFG_ERASE_EN_BIT]
            && erase_busy_out;
    endproperty
    a_erase_gate: assert property (p_erase_gate)
        else $error("erase started while disabled");
    property p_erase_prompt;
        decide && q.byte_idx == 2'd1 && q.shift == CMD_PAGE_ERASE
            && q.cfg[UPD_CFG_ERASE_EN_BIT] |=> erase_start_out
            && erase_page_out == $past(q.ptr[PAGE_MSB:PAGE_LSB]);
    endproperty
    a_erase_prompt: assert property (p_erase_prompt)
        else $error("erase not launched on its command byte");
    property p_busy_refuses;
        decide && q.byte_idx == 2'd0 && erase_busy_out |=> q.st == ST_IDLE;
    endproperty
    a_busy_refuses: assert property (p_busy_refuses)
        else $error("address acknowledged during erase");
    property p_nack_release;
        q.st == ST_TX_ACK && scl_fall && q.nack && !start_det && !stop_det
            |=> q.st == ST_IDLE && sda_oe_b_out;
    endproperty
    a_nack_release: assert property (p_nack_release)
        else $error("sda still driven after master nack");

    c_erase: cover property (erase_start_out);
    c_read_byte: cover property (q.st == ST_TX_ACK && scl_fall);
    c_write_push: cover property (push);
    c_refused: cover property (decide && !ack);
endmodule
`default_nettype wire

// ---- testbench/smbsl_master_model.sv ----
// bus master model that drives scl and the data line open drain
`timescale 1ns/10ps
`default_nettype none
module smbsl_master_model
(
    input wire logic sys_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_b_out
);
    // ************************************************************
    // bit timing
    // ************************************************************
    // scl stands high between frames; a quarter link period is 100 ns
    initial
    begin
        scl_out = 1'b1;
        sda_oe_b_out = 1'b1;
    end

    task automatic quarter();
        repeat (2) @(posedge sys_clk_in);
        #2;
    endtask

    // data moves only in the low phase, sampled mid high phase
    task automatic bit_cycle(input logic drv, output logic seen);
        quarter();
        sda_oe_b_out = drv;
        quarter();
        scl_out = 1'b1;
        quarter();
        seen = sda_in;
        quarter();
        scl_out = 1'b0;
    endtask

    // ************************************************************
    // framing
    // ************************************************************
    task automatic start_cond();
        quarter();
        sda_oe_b_out = 1'b1;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_oe_b_out = 1'b0;
        quarter();
        scl_out = 1'b0;
    endtask

    task automatic stop_cond();
        quarter();
        sda_oe_b_out = 1'b0;
        quarter();
        scl_out = 1'b1;
        quarter();
        sda_oe_b_out = 1'b1;
        quarter();
    endtask

    // eight bits msb first, then the ninth clock for acknowledge
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], s);
        bit_cycle(1'b1, s);
        ack = (s === 1'b0);
    endtask

    // the last byte is left unacknowledged before stop
    task automatic rd_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b1, b[i]);
        bit_cycle(~give_ack, s);
    endtask
endmodule
`default_nettype wire

// ---- testbench/smbus_slave_mem_access_bench.sv ----
// self-checking bench for the smbus slave front end
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_mem_access_bench;
    import smbsl_pkg::*;
    localparam int unsigned ERASE_T = 200;
    localparam int LIMIT = 40000;
    localparam logic [7:0] AW = {SLAVE_ADDR_FIXED, 2'b01, 1'b0};
    localparam logic [15:0] EP = 16'hf965;
    typedef struct {
        logic hi;
        logic lo;
        logic [7:0] a;
        logic [7:0] cmd;
        int acks;
        logic [15:0] ptr;
    } smbsl_row_t;
    logic sys_clk, rst_b, sel_hi, sel_lo, wr_ready, m_scl, m_oe_b, s_sda;
    logic s_oe_b, wr_valid, erase_start, erase_busy;
    logic [15:0] ptr, wr_addr;
    logic [7:0] rd_data, wr_data, cfg;
    logic [4:0] page;
    wire sda_line;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    int busy_cyc = 0;
    int starts = 0;
    int n;
    logic [7:0] q[$];
    smbsl_row_t rows[5];

    // released line is pulled up; any party may pull it low
    assign sda_line = m_oe_b & (s_oe_b ? 1'b1 : s_sda);
    assign rd_data = ptr[7:0] ^ 8'h5a;

    smbsl_slave #(.ERASE_CYCLES(ERASE_T)) smbsl_slave_inst (
        .sys_clk_in(sys_clk), .rst_b_in(rst_b), .scl_in(m_scl),
        .sda_in(sda_line), .sda_out(s_sda), .sda_oe_b_out(s_oe_b),
        .address_select_hi_in(sel_hi), .address_select_lo_in(sel_lo),
        .ptr_out(ptr), .rd_data_in(rd_data), .wr_valid_out(wr_valid),
        .wr_ready_in(wr_ready), .wr_addr_out(wr_addr),
        .wr_data_out(wr_data), .update_config_control_out(cfg),
        .erase_start_out(erase_start), .erase_busy_out(erase_busy),
        .erase_page_out(page));
    smbsl_master_model smbsl_master_model_inst (.sys_clk_in(sys_clk),
        .sda_in(sda_line), .scl_out(m_scl), .sda_oe_b_out(m_oe_b));

    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (erase_busy === 1'b1)
            busy_cyc <= busy_cyc + 1;
        if (erase_start === 1'b1)
            starts <= starts + 1;
        if (cyc == LIMIT)
        begin
            n_mismatch++;
            wrap_up();
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_frame(input logic [7:0] b[$], output int acks);
        logic a;
        acks = 0;
        smbsl_master_model_inst.start_cond();
        foreach (b[i])
        begin
            smbsl_master_model_inst.wr_byte(b[i], a);
            acks += int'(a);
        end
        smbsl_master_model_inst.stop_cond();
    endtask

    task automatic rd_chk(input logic [7:0] exp[$]);
        logic a;
        logic [7:0] b;
        smbsl_master_model_inst.start_cond();
        smbsl_master_model_inst.wr_byte(AW | 8'h01, a);
        foreach (exp[i])
        begin
            smbsl_master_model_inst.rd_byte(i < exp.size() - 1, b);
            chk("read byte", 24'(b), 24'(exp[i]));
        end
        repeat (6) @(posedge sys_clk);
        #2;
        chk("release after nack", 24'(s_oe_b), 24'h1);
        smbsl_master_model_inst.stop_cond();
    endtask

    task automatic pop_one();
        @(posedge sys_clk);
        #2;
        wr_ready = 1'b1;
        @(posedge sys_clk);
        #2;
        wr_ready = 1'b0;
    endtask

    task automatic wrap_up();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        rows[0] = '{0, 0, {SLAVE_ADDR_FIXED, 3'b000}, 8'h00, 2, 16'h0000};
        rows[1] = '{1, 0, {SLAVE_ADDR_FIXED, 3'b100}, 8'hdf, 2, 16'h00df};
        rows[2] = '{1, 1, {SLAVE_ADDR_FIXED, 3'b110}, 8'h37, 2, 16'h0037};
        rows[3] = '{0, 1, {SLAVE_ADDR_FIXED, 3'b000}, 8'h55, 0, 16'h0037};
        rows[4] = '{0, 1, AW, 8'h80, 2, 16'h0080};
        rst_b = 1'b0;
        sel_hi = 1'b0;
        sel_lo = 1'b0;
        wr_ready = 1'b0;
        repeat (8) @(posedge sys_clk);
        #2;
        chk("oe in reset", 24'(s_oe_b), 24'h1);
        chk("cfg reset", 24'(cfg), 24'(UPD_CFG_RESET));
        chk("ptr reset", 24'(ptr), 24'h0);
        rst_b = 1'b1;
        repeat (6) @(posedge sys_clk);
        foreach (rows[i])
        begin
            sel_hi = rows[i].hi;
            sel_lo = rows[i].lo;
            repeat (4) @(posedge sys_clk);
            wr_frame('{rows[i].a, rows[i].cmd}, n);
            chk("acks", 24'(n), 24'(rows[i].acks));
            chk("ptr", 24'(ptr), 24'(rows[i].ptr));
        end
        wr_frame('{AW, CMD_PAGE_ERASE}, n);
        chk("erase off acks", 24'(n), 24'h2);
        chk("erase off", 24'(starts), 24'h0);
        wr_frame('{AW, 8'h90, 8'h04}, n);
        chk("cfg acks", 24'(n), 24'h3);
        chk("cfg", 24'(cfg), 24'h04);
        chk("push", {wr_valid, wr_addr[14:0], wr_data}, 24'h809004);
        pop_one();
        chk("fifo empty", 24'(wr_valid), 24'h0);
        wr_frame('{AW, 8'h90}, n);
        rd_chk('{8'h04});
        wr_frame('{AW, 8'h10}, n);
        rd_chk('{8'h10 ^ 8'h5a, 8'h11 ^ 8'h5a});
        wr_frame('{AW, EP[15:8], EP[7:0]}, n);
        chk("ee ptr", 24'(ptr), 24'(EP));
        wr_frame('{AW, CMD_PAGE_ERASE}, n);
        chk("erase acks", 24'(n), 24'h2);
        chk("erase start", 24'(starts), 24'h1);
        chk("page", 24'(page), 24'(EP[9:5]));
        wr_frame('{AW}, n);
        chk("busy nack", 24'(n), 24'h0);
        for (int i = 0; i < 400 && erase_busy !== 1'b0; i++)
            @(posedge sys_clk);
        #2;
        chk("busy length", 24'(busy_cyc), 24'(ERASE_T));
        wr_frame('{AW, EP[15:8], EP[7:0], 8'h3c}, n);
        chk("ack after erase", 24'(n), 24'h4);
        wr_frame('{AW, CMD_BLOCK_WRITE, 8'h01, 8'h5c}, n);
        chk("block acks", 24'(n), 24'h4);
        chk("ee push", {wr_addr, wr_data}, {EP, 8'h3c});
        pop_one();
        chk("block push", {wr_addr, wr_data}, {EP + 16'h0001, 8'h5c});
        pop_one();
        chk("popped", 24'(wr_valid), 24'h0);
        q = '{AW, 8'h20};
        for (int i = 0; i < 17; i++)
            q.push_back(8'(i));
        wr_frame(q, n);
        chk("fill acks", 24'(n), 24'(WR_FIFO_DEPTH + 2));
        for (int i = 0; i < WR_FIFO_DEPTH; i++)
        begin
            repeat (2) @(posedge sys_clk);
            #2;
            chk("drain", {wr_valid, wr_addr[14:0], wr_data},
                {1'b1, 15'(16'h0020 + i), 8'(i)});
            wr_ready = 1'b1;
            @(posedge sys_clk);
            #2;
            wr_ready = 1'b0;
        end
        chk("drained", 24'(wr_valid), 24'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
